// [clk_pwr_pkg.sv]
// Package: register map, field layout, reset values and mode encodings
package clk_pwr_pkg;
    // Register offsets
    localparam logic [15:0] POWER_MODE_CONTROL_OFS = 16'hF800;
    localparam logic [15:0] CLOCK_PRESCALE_CONTROL_OFS = 16'hF804;
    // Reset values
    localparam logic [7:0] POWER_MODE_CONTROL_RST = 8'h00;
    localparam logic [15:0] CLOCK_PRESCALE_CONTROL_RST = 16'h0000;
    // Field layout
    localparam int PRESCALE_FIELD_W = 9;
    localparam int PRESCALE_FIELD_LSB = 0;
    localparam int COMPARE_W = 8;
    localparam int POWER_MODE_FIELD_LSB = 0;
    localparam int POWER_MODE_FIELD_W = 2;
    // Power mode encodings of the two-bit field
    localparam logic [1:0] PM_ACTIVE0 = 2'h0;
    localparam logic [1:0] PM_IDLE = 2'h1;
    localparam logic [1:0] PM_POWERDOWN = 2'h2;
    localparam logic [1:0] PM_ACTIVE1 = 2'h3;

    // Power state, Gray coded along active-idle-powerdown
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_IDLE = 2'b01,
        ST_POWERDOWN = 2'b11
    } pwr_state_e;

    // Wake sources travel together
    typedef struct packed {
        logic nmi;
        logic management_irq_n;
        logic irq;
    } wake_s;

    // Phase clock bundle
    typedef struct packed {
        logic core_phase_one;
        logic core_phase_two;
        logic periph_phase_one;
        logic periph_phase_two;
    } phase_s;
endpackage : clk_pwr_pkg

// [clock_prescaler_power_modes.sv]
// Clock prescaler and power mode control logic
`timescale 1ns/1ps

// Overview of operation
// - Prescaled clock has 50% duty and feeds timer and serial units.
// - Divisor equals nine-bit prescale field with low bit cleared, plus two, range 2 to 512.
// - Reset clears prescale, compare, toggle: output starts at quarter input rate.
// - Eight-bit counter increments and compares once per state time.
// - Match while low: drive high, clear counter, keep compare value.
// - Next match: drive low, clear counter, reload compare from upper eight bits.
// - New divisor applies only after current division completes.
// - Software writes mode then halts; mode entered when ready ends halt cycle.
// - Idle freezes core phases (one low, two high); peripheral phases run.
// - Reset, nmi, management irq or unmasked irq wake from idle or powerdown.
// - Powerdown freezes core and peripheral phases, stopping prescaled clock.
// - Sleep indicator goes high when clocks stop in powerdown, if enabled.
module clock_prescaler_power_modes
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    // Halt cycle from core
    input wire logic halt_cycle,
    input wire logic ready_n,
    // Wake sources
    input wire clk_pwr_pkg::wake_s wake,
    // Pin function select for sleep indicator
    input wire logic sleep_pin_enable,
    // Clock outputs
    output clk_pwr_pkg::phase_s phases,
    output logic prescaled_clock,
    output logic sleep_indicator,
    output logic idle
);
    import clk_pwr_pkg::*;

    // Block structure, in order below:
    // - software registers for power mode and prescale field
    // - registered read path, zero outside the read cycle
    // - power state machine driven by the halt bus cycle
    // - phase generator with separate core and peripheral gating
    // - state time tick derived from the peripheral phases
    // - prescale divider with deferred compare reload
    // - registered status outputs for idle and sleep
    //
    // All state sits in one clock domain; slower rates are enables.
    // The phase outputs are registered, so consumers see clean levels.
    // Gating is by freezing registered levels, never by gating clk.

    // Prescale field layout: odd bit folds into the half-period split
    // Limitation: odd fields lose their low bit, so the divisor rounds down
    // to an even count; this keeps both halves equal at every setting.
    function automatic logic [COMPARE_W-1:0] upper_bits(input logic [PRESCALE_FIELD_W-1:0] f);
        upper_bits = f[PRESCALE_FIELD_W-1:1];
    endfunction : upper_bits

    logic [POWER_MODE_FIELD_W-1:0] power_mode_field_q;
    logic [POWER_MODE_FIELD_W-1:0] power_mode_field_d;
    logic [PRESCALE_FIELD_W-1:0] prescale_field_q;
    logic [PRESCALE_FIELD_W-1:0] prescale_field_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic wake_any;

    // Registers written by software
    // Reserved bits are dropped on write and read back as zero.
    // Unmapped addresses leave both registers untouched.
    // A prescale write only changes the staged field; the divider
    // picks it up at its own reload point further down.
    always_comb
    begin
        power_mode_field_d = power_mode_field_q;
        prescale_field_d = prescale_field_q;
        if (wr_stb && addr == POWER_MODE_CONTROL_OFS)
            power_mode_field_d = wdata[POWER_MODE_FIELD_LSB +: POWER_MODE_FIELD_W];
        if (wr_stb && addr == CLOCK_PRESCALE_CONTROL_OFS)
            prescale_field_d = wdata[PRESCALE_FIELD_LSB +: PRESCALE_FIELD_W];
    end

    // Read data one cycle after strobe; unmapped reads zero
    // Returning zero outside the read cycle keeps a shared read mux
    // free of stale values, at the cost of one extra register.
    always_comb
    begin
        rdata_d = 16'h0000;
        if (rd_stb && addr == POWER_MODE_CONTROL_OFS)
            rdata_d = {14'h0000, power_mode_field_q};
        else if (rd_stb && addr == CLOCK_PRESCALE_CONTROL_OFS)
            rdata_d = {7'h00, prescale_field_q};
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            power_mode_field_q <= POWER_MODE_CONTROL_RST[POWER_MODE_FIELD_W-1:0];
            prescale_field_q <= CLOCK_PRESCALE_CONTROL_RST[PRESCALE_FIELD_W-1:0];
            rdata_q <= 16'h0000;
        end
        else
        begin
            power_mode_field_q <= power_mode_field_d;
            prescale_field_q <= prescale_field_d;
            rdata_q <= rdata_d;
        end
    end
    assign rdata = rdata_q;

    // Power state machine
    // Entry happens only from active and only on the edge at which the
    // halt cycle is terminated by ready; mode bits alone change nothing.
    // Exit is on any wake level, so an interrupt that is already pending
    // when the halt ends keeps the device active instead.
    // Mode bits are left as written, so the next halt re-enters the mode.
    pwr_state_e state_q;
    pwr_state_e state_d;
    // Level sensitive wake; an active level also blocks entry
    assign wake_any = wake.nmi | ~wake.management_irq_n | wake.irq;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_ACTIVE:
            begin
                // Entry only when ready ends the halt bus cycle
                if (halt_cycle && !ready_n && !wake_any)
                begin
                    unique case (power_mode_field_q)
                        PM_IDLE: state_d = ST_IDLE;
                        PM_POWERDOWN: state_d = ST_POWERDOWN;
                        default: state_d = ST_ACTIVE;
                    endcase
                end
            end
            ST_IDLE:
                if (wake_any)
                    state_d = ST_ACTIVE;
            ST_POWERDOWN:
                if (wake_any)
                    state_d = ST_ACTIVE;
            default: state_d = ST_ACTIVE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            state_q <= ST_ACTIVE;
        else
            state_q <= state_d;
    end

    // Phase generator: each clk edge alternates phase one and two
    // The free-running phase bit never stops, so a wake resumes the
    // gated phases in step with the rest of the device.
    // Core phases run only in active; peripheral phases also in idle.
    logic phase_q;
    logic phase_d;
    logic core_run;
    logic periph_run;
    assign core_run = (state_q == ST_ACTIVE);
    assign periph_run = (state_q != ST_POWERDOWN);
    assign phase_d = ~phase_q;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            phase_q <= 1'b0;
        else
            phase_q <= phase_d;
    end

    // Frozen phases park with one low and two high
    phase_s phases_d;
    phase_s phases_q;
    always_comb
    begin
        phases_d.core_phase_one = core_run & phase_d;
        phases_d.core_phase_two = ~core_run | ~phase_d;
        phases_d.periph_phase_one = periph_run & phase_d;
        phases_d.periph_phase_two = ~periph_run | ~phase_d;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            phases_q <= '0;
        else
            phases_q <= phases_d;
    end
    assign phases = phases_q;

    // State time tick: one per phase-one/phase-two pair, only while peripherals run
    // Tying the tick to the peripheral gate is what stops the prescaled
    // clock in powerdown while letting it run on through idle.
    logic tick;
    assign tick = phase_q & periph_run;

    // Prescale divider; counter and compare both eight bits
    // Each half period lasts compare plus one ticks, two clk per tick.
    // After reset compare is zero, so the output toggles every tick,
    // which is one quarter of the clk rate.
    // The compare value is only refreshed at the end of a high half, so
    // a write mid-division never shortens or splits a period.
    logic [COMPARE_W-1:0] count_q;
    logic [COMPARE_W-1:0] count_d;
    logic [COMPARE_W-1:0] compare_q;
    logic [COMPARE_W-1:0] compare_d;
    logic prescaled_clock_q;
    logic prescaled_clock_d;
    logic match;
    assign match = (count_q == compare_q);

    always_comb
    begin
        count_d = count_q;
        compare_d = compare_q;
        prescaled_clock_d = prescaled_clock_q;
        if (tick)
        begin
            if (match && !prescaled_clock_q)
            begin
                prescaled_clock_d = 1'b1;
                count_d = '0;
            end
            else if (match)
            begin
                // Reload only here so a running division is never cut short
                prescaled_clock_d = 1'b0;
                count_d = '0;
                compare_d = upper_bits(prescale_field_q);
            end
            else
                count_d = count_q + 8'h01;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            count_q <= '0;
            compare_q <= '0;
            prescaled_clock_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            compare_q <= compare_d;
            prescaled_clock_q <= prescaled_clock_d;
        end
    end
    // Equal half periods give the 50% duty for even divisors
    assign prescaled_clock = prescaled_clock_q;

    // Status outputs registered after clocks freeze
    // Both flags move on the same edge as the frozen phase levels, so
    // observers never see the flag ahead of the clocks actually stopping.
    // The sleep flag is only shown when the pin carries that function;
    // powerdown itself does not depend on the pin setting.
    logic sleep_q;
    logic sleep_d;
    logic idle_q;
    logic idle_d;
    assign sleep_d = sleep_pin_enable & (state_q == ST_POWERDOWN);
    assign idle_d = (state_q == ST_IDLE);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            sleep_q <= 1'b0;
            idle_q <= 1'b0;
        end
        else
        begin
            sleep_q <= sleep_d;
            idle_q <= idle_d;
        end
    end
    assign sleep_indicator = sleep_q;
    assign idle = idle_q;
endmodule : clock_prescaler_power_modes

// [halt_core_model.sv]
// Core model: halt bus cycles ended by ready
`timescale 1ns/1ps
module halt_core_model
(
    // Request from bench
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] dly,
    // Halt cycle to block
    output logic halt_cycle,
    output logic ready_n
);
    logic [3:0] cnt_q = 4'h0;
    initial {halt_cycle, ready_n} = 2'h1;
    // Ready low one cycle ends the halt; large dly gives a slow core
    always @(posedge clk)
    begin
        ready_n <= 1'h1;
        if (go) {halt_cycle, cnt_q} <= {1'h1, dly};
        else if (!ready_n) halt_cycle <= 1'h0;
        else if (halt_cycle && cnt_q == 4'h0) ready_n <= 1'h0;
        else if (halt_cycle) cnt_q <= cnt_q - 4'h1;
    end
endmodule : halt_core_model

// [clock_prescaler_power_modes_chk.sv]
// Checker: prescaler timing, register reads, power entry and exit
`timescale 1ns/1ps
module clock_prescaler_power_modes_chk
(
    // Clock, reset, register port
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [15:0] rdata,
    // Core side
    input wire logic halt_cycle,
    input wire logic ready_n,
    input wire clk_pwr_pkg::wake_s wake,
    input wire logic sleep_pin_enable,
    // Clock outputs
    input wire clk_pwr_pkg::phase_s phases,
    input wire logic prescaled_clock,
    input wire logic sleep_indicator,
    input wire logic idle
);
    import clk_pwr_pkg::*;
    logic [8:0] pre_q;
    logic [1:0] mode_q;
    logic [7:0] cmp_q;
    logic [9:0] hp_q;
    logic [15:0] rexp_q;
    logic ok_q, wk, hlt;
    // Any wake level blocks entry, so a taken halt needs all quiet
    assign wk = wake.nmi | ~wake.management_irq_n | wake.irq;
    assign hlt = halt_cycle & ~ready_n & ~wk & ~idle & ~sleep_indicator;
    // Register mirror; compare reloads only on the falling edge
    always_ff @(posedge clk)
    begin
        if (wr_stb && addr == CLOCK_PRESCALE_CONTROL_OFS) pre_q <= wdata[8:0];
        if (wr_stb && addr == POWER_MODE_CONTROL_OFS) mode_q <= wdata[1:0];
        if ($fell(prescaled_clock)) cmp_q <= pre_q[8:1];
        // Any stall of the peripheral phases drops the half-period reference
        ok_q <= $changed(phases.periph_phase_two) & (ok_q | $changed(prescaled_clock));
        rexp_q <= !rd_stb ? 16'h0000 : addr == CLOCK_PRESCALE_CONTROL_OFS ? {7'h00, pre_q}
            : addr == POWER_MODE_CONTROL_OFS ? {14'h0000, mode_q} : 16'h0000;
        hp_q <= $changed(prescaled_clock) ? 10'h001 : hp_q + 10'h001;
        if (!rst_b) {pre_q, mode_q, cmp_q, ok_q, rexp_q} <= '0;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // First half after reset or powerdown has no known start, so it is skipped
    property p_half;
        ok_q && $changed(prescaled_clock) |-> hp_q == {1'h0, cmp_q, 1'h0} + 10'h002;
    endproperty
    a_half: assert property (p_half) else $error("half period");
    property p_read; rdata == rexp_q; endproperty
    a_read: assert property (p_read) else $error("read data");
    property p_idle_core; idle |-> !phases.core_phase_one && phases.core_phase_two; endproperty
    a_idle_core: assert property (p_idle_core) else $error("core phases in idle");
    property p_pd_freeze; sleep_indicator |-> phases == 4'h5; endproperty
    a_pd_freeze: assert property (p_pd_freeze) else $error("phases in powerdown");
    property p_enter_idle; hlt && mode_q == PM_IDLE |-> ##[1:3] idle; endproperty
    a_enter_idle: assert property (p_enter_idle) else $error("idle not entered");
    property p_enter_pd;
        hlt && sleep_pin_enable && mode_q == PM_POWERDOWN |-> ##[1:3] sleep_indicator;
    endproperty
    a_enter_pd: assert property (p_enter_pd) else $error("no sleep");
    property p_same; hlt && mode_q[1] == mode_q[0] |-> ##1 (!idle && !sleep_indicator) [*3]; endproperty
    a_same: assert property (p_same) else $error("left active");
    property p_wake; wk && (idle || sleep_indicator) |-> ##[1:3] (!idle && !sleep_indicator); endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    // Main scenarios reached
    c_idle: cover property (idle);
    c_sleep: cover property (sleep_indicator);
    c_reload: cover property ($fell(prescaled_clock) && pre_q[8:1] != cmp_q);
endmodule : clock_prescaler_power_modes_chk

bind clock_prescaler_power_modes clock_prescaler_power_modes_chk
    clock_prescaler_power_modes_chk_inst (.clk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .halt_cycle, .ready_n, .wake, .sleep_pin_enable, .phases, .prescaled_clock,
    .sleep_indicator, .idle);

// [clock_prescaler_power_modes_tb.sv]
// Testbench: register rows, then halt, wake and powerdown cases
`timescale 1ns/1ps
module clock_prescaler_power_modes_tb;
    import clk_pwr_pkg::*;
    typedef struct packed {logic [15:0] a; logic [15:0] w; logic [15:0] r;} row_s;
    // Address, written value, value read back
    row_s rows [7] = '{'{16'hF804, 16'h0003, 16'h0003}, '{16'hF804, 16'h0002, 16'h0002},
        '{16'hF804, 16'h0009, 16'h0009}, '{16'hF800, 16'h00FF, 16'h0003},
        '{16'hF802, 16'h1234, 16'h0000}, '{16'hF804, 16'hFFFF, 16'h01FF},
        '{16'hF804, 16'h0000, 16'h0000}};
    logic clk = 1'h0, rst_b = 1'h0, wr_stb = 1'h0, rd_stb = 1'h0, go = 1'h0;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata, v;
    logic [3:0] dly = 4'h0;
    logic sleep_en = 1'h1;
    wake_s wake = 3'h2;
    phase_s phases;
    logic halt_cycle, ready_n, prescaled_clock, sleep_indicator, idle;
    int error_cnt = 0;
    int n_compared = 0;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    clock_prescaler_power_modes clock_prescaler_power_modes_inst (.clk, .rst_b, .addr,
        .wdata, .wr_stb, .rd_stb, .rdata, .halt_cycle, .ready_n, .wake,
        .sleep_pin_enable(sleep_en), .phases, .prescaled_clock, .sleep_indicator, .idle);
    halt_core_model halt_core_model_inst (.clk, .go, .dly, .halt_cycle, .ready_n);
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) error_cnt++;
        if (g !== e) $display("wrong value %s expected %h seen %h", n, e, g);
    endtask : chk
    // One strobe cycle; read data is taken in the cycle after
    task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        {wr_stb, rd_stb, addr, wdata} <= {w, ~w, a, d};
        @(posedge clk);
        {wr_stb, rd_stb} <= 2'h0;
        #1 v = rdata;
    endtask : bus
    task automatic halt(input logic [1:0] m, input logic [3:0] d);
        bus(1'h1, POWER_MODE_CONTROL_OFS, {14'h0000, m});
        @(posedge clk);
        {go, dly} <= {1'h1, d};
        @(posedge clk);
        go <= 1'h0;
        repeat (24) @(posedge clk);
        #1;
    endtask : halt
    task automatic wake_up(input wake_s w);
        @(posedge clk);
        wake <= w;
        repeat (4) @(posedge clk);
        wake <= 3'h2;
        #1 chk("awake", 16'h0000, {14'h0000, idle, sleep_indicator});
    endtask : wake_up
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'h1;
        bus(1'h0, POWER_MODE_CONTROL_OFS, 16'h0000);
        chk("power reset", {8'h00, POWER_MODE_CONTROL_RST}, v);
        bus(1'h0, CLOCK_PRESCALE_CONTROL_OFS, 16'h0000);
        chk("prescale reset", CLOCK_PRESCALE_CONTROL_RST, v);
        $display("reset test done");
        foreach (rows[i])
        begin
            bus(1'h1, rows[i].a, rows[i].w);
            bus(1'h0, rows[i].a, 16'h0000);
            chk("readback", rows[i].r, v);
            repeat (40) @(posedge clk);
        end
        // Long division from 1FF must finish before the zero takes over
        repeat (1100) @(posedge clk);
        $display("register test done");
        for (int k = 0; k < 3; k++)
        begin
            halt(PM_IDLE, 4'(k * 6));
            chk("idle", 16'h0005, {13'h0000, idle, phases.core_phase_one, phases.core_phase_two});
            wake_up(3'h2 ^ (3'h4 >> k));
        end
        for (int k = 0; k < 2; k++)
        begin
            halt(k ? PM_ACTIVE1 : PM_ACTIVE0, 4'h2);
            chk("active", 16'h0000, {14'h0000, idle, sleep_indicator});
        end
        @(posedge clk);
        wake <= 3'h3;
        halt(PM_IDLE, 4'h1);
        chk("blocked", 16'h0000, {15'h0000, idle});
        wake_up(3'h2);
        $display("idle test done");
        halt(PM_POWERDOWN, 4'hF);
        v[0] = prescaled_clock;
        chk("powerdown", 16'h0015, {11'h000, sleep_indicator, phases});
        repeat (30) @(posedge clk);
        #1 chk("frozen", {15'h0000, v[0]}, {15'h0000, prescaled_clock});
        wake_up(3'h0);
        repeat (60) @(posedge clk);
        // Pin not configured: clocks still stop, indicator stays low
        @(posedge clk);
        sleep_en <= 1'h0;
        halt(PM_POWERDOWN, 4'h3);
        chk("no pin", 16'h0005, {11'h000, sleep_indicator, phases});
        wake_up(3'h0);
        @(posedge clk);
        sleep_en <= 1'h1;
        repeat (60) @(posedge clk);
        $display("powerdown test done");
        stop_test();
    end
    // Watchdog well beyond the fewer than two thousand cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        stop_test();
    end
endmodule : clock_prescaler_power_modes_tb
